// ---- logic/rct_cfg.svh ----
`ifndef RCT_CFG_SVH
`define RCT_CFG_SVH

// register indices, byte address is four times the index
`define RCT_IDX_T2_CTRL     8'h19
`define RCT_IDX_T2_RLD_HI   8'h1A
`define RCT_IDX_T2_RLD_LO   8'h1B
`define RCT_IDX_T2_CNT_HI   8'h1C
`define RCT_IDX_T2_CNT_LO   8'h1D
`define RCT_IDX_T3_CTRL     8'h1F
`define RCT_IDX_STATUS      8'h30
`define RCT_IDX_MASK        8'h31
`define RCT_IDX_T3_RLD_HI   8'h32
`define RCT_IDX_T3_RLD_LO   8'h33
`define RCT_IDX_T3_CNT_HI   8'h34
`define RCT_IDX_T3_CNT_LO   8'h35
`define RCT_IDX_COMMAND     8'h36

// control field layout
`define RCT_STOP_RX_BIT     7
`define RCT_START_MSB       5
`define RCT_START_LSB       4
`define RCT_AUTO_BIT        3
`define RCT_TICK_MSB        1
`define RCT_TICK_LSB        0
`define RCT_CTRL_MASK       8'hBB

// status, mask and command bits
`define RCT_ST_T2_BIT       0
`define RCT_ST_T3_BIT       1
`define RCT_CMD_START2_BIT  0
`define RCT_CMD_STOP2_BIT   1
`define RCT_CMD_START3_BIT  2
`define RCT_CMD_STOP3_BIT   3

// reset values
`define RCT_CTRL_RST        8'h00
`define RCT_RELOAD_RST      8'h00
`define RCT_MASK_RST        2'h0

// bus answers
`define RCT_RESP_OKAY       2'h0
`define RCT_RESP_SLVERR     2'h2

// timing
`define RCT_CLK_PERIOD_NS   10
`define RCT_CLK_HZ          (1000000000 / `RCT_CLK_PERIOD_NS)
`define RCT_SYS_TICK_HZ     13560000
`define RCT_LOW_TICK_HZ     212000

`endif

// ---- logic/rct_pkg.sv ----
package rct_pkg;

   typedef enum logic [1:0] {
      RCT_START_MANUAL  = 2'b00,
      RCT_START_TX_END  = 2'b01,
      RCT_START_TRIM    = 2'b10,
      RCT_START_TRIM_UF = 2'b11
   } rct_start_mode_t;

   typedef enum logic [1:0] {
      RCT_TICK_SYS   = 2'b00,
      RCT_TICK_LOW   = 2'b01,
      RCT_TICK_ZERO  = 2'b10,
      RCT_TICK_ONE   = 2'b11
   } rct_tick_sel_t;

   typedef enum logic [0:0] {
      RCT_WR_WAIT = 1'b0,
      RCT_WR_RESP = 1'b1
   } rct_wr_state_t;

   typedef enum logic [0:0] {
      RCT_RD_IDLE = 1'b0,
      RCT_RD_DATA = 1'b1
   } rct_rd_state_t;

endpackage

// ---- logic/rct_down_counter.sv ----
`timescale 1ns/1ps

module rct_down_counter (
   input  wire logic        clock,
   input  wire logic        nrst,
   input  wire logic        start,
   input  wire logic        stop,
   input  wire logic        tick,
   input  wire logic [15:0] reload_value,
   input  wire logic        auto_reload,
   input  wire logic        wrap_en,
   output logic      [15:0] count,
   output logic             running,
   output logic             underflow
);

   logic [15:0] count_r;
   logic [15:0] count_nxt;
   logic        run_r;
   logic        run_nxt;
   logic        uf_r;
   logic        uf_nxt;

   always_comb begin
      count_nxt = count_r;
      run_nxt   = run_r;
      uf_nxt    = 1'b0;
      if (start) begin
         // RQ10 load on start
         count_nxt = reload_value;
         run_nxt   = 1'b1;
      end else if (stop) begin
         run_nxt = 1'b0;
      end else if (run_r && tick) begin
         if (count_r == 16'h0000) begin
            if (wrap_en) begin
               // RQ17 underflow pulse
               uf_nxt = 1'b1;
               if (auto_reload) begin
                  // RQ5 reload and go on
                  count_nxt = reload_value;
               end else begin
                  // RQ6 stop holding zero
                  run_nxt = 1'b0;
               end
            end else begin
               run_nxt = 1'b0;
            end
         end else begin
            // RQ17 one per tick
            count_nxt = count_r - 16'h0001;
         end
      end
   end

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         count_r <= 16'h0000;
         run_r   <= 1'b0;
         uf_r    <= 1'b0;
      end else begin
         count_r <= count_nxt;
         run_r   <= run_nxt;
         uf_r    <= uf_nxt;
      end
   end

   assign count     = count_r;
   assign running   = run_r;
   assign underflow = uf_r;

endmodule // rct_down_counter

// ---- logic/rct_timer.sv ----
// How it works
// RQ1: stop-on-receive set halts count after first four received bits; clear means no stop.
// RQ2: in oscillator trimming modes the stop-on-receive bit is ignored.
// RQ3: start mode 00b never auto-starts; 01b starts when transmission ends.
// RQ4: modes 10b/11b trim; oscillator rising edges start and stop; 11b handles underflow.
// RQ5: auto-restart set: at zero reload the reload value and keep counting.
// RQ6: auto-restart clear: count to zero, stop, hold zero until restarted.
// RQ7: every underflow sets the second timer interrupt flag.
// RQ8: tick select 00b uses 13.56 MHz tick, 01b uses 212 kHz tick.
// RQ9: tick select 10b counts timer zero underflows, 11b timer one underflows.
// RQ10: each start loads counter from the 16-bit reload value of both bytes.
// RQ11: reload byte writes affect only the next start, not a running count; here a running count also takes them at its next auto-reload.
// RQ12: running count readable as high byte at 1Ch and low byte at 1Dh.
// RQ13: software should not read count bytes while receiving; value may be invalid.
// RQ14: third timer control uses same field layout, reserved bits 6 and 2.
// RQ15: second timer control register sits at index 19h.
// RQ16: third timer also restarts from its own reload value with auto-restart.
// RQ17: counter drops one per selected tick and pulses underflow for cascading.
// RQ18: reserved control bits read zero and ignore writes.
`timescale 1ns/1ps
`include "rct_cfg.svh"

module rct_timer (
   input  wire logic        clock,
   input  wire logic        nrst,
   input  wire logic [11:0] s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic      [1:0]  s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [11:0] s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic      [31:0] s_axi_rdata,
   output logic      [1:0]  s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   input  wire logic        tx_end,
   input  wire logic        rx_first_nibble,
   input  wire logic        low_freq_oscillator,
   input  wire logic        timer_zero_underflow,
   input  wire logic        timer_one_underflow,
   output logic             irq,
   output logic             second_timer_underflow,
   output logic             third_timer_underflow,
   output logic             second_timer_running,
   output logic             third_timer_running
);

   localparam logic [27:0] CLK_HZ  = 28'(`RCT_CLK_HZ);
   localparam logic [27:0] SYS_HZ  = 28'(`RCT_SYS_TICK_HZ);
   localparam logic [27:0] LOW_HZ  = 28'(`RCT_LOW_TICK_HZ);

   // bus state
   rct_pkg::rct_wr_state_t wr_state_r;
   rct_pkg::rct_wr_state_t wr_state_nxt;
   rct_pkg::rct_rd_state_t rd_state_r;
   rct_pkg::rct_rd_state_t rd_state_nxt;
   logic        aw_held_r;
   logic        aw_held_nxt;
   logic [11:0] aw_addr_r;
   logic [11:0] aw_addr_nxt;
   logic        w_held_r;
   logic        w_held_nxt;
   logic [7:0]  w_byte_r;
   logic [7:0]  w_byte_nxt;
   logic        w_lane_r;
   logic        w_lane_nxt;
   logic        awready_r;
   logic        awready_nxt;
   logic        wready_r;
   logic        wready_nxt;
   logic        bvalid_r;
   logic        bvalid_nxt;
   logic [1:0]  bresp_r;
   logic [1:0]  bresp_nxt;
   logic        arready_r;
   logic        arready_nxt;
   logic        rvalid_r;
   logic        rvalid_nxt;
   logic [1:0]  rresp_r;
   logic [1:0]  rresp_nxt;
   logic [31:0] rdata_r;
   logic [31:0] rdata_nxt;

   // registers
   logic [7:0]  ctrl2_r;
   logic [7:0]  ctrl2_nxt;
   logic [7:0]  ctrl3_r;
   logic [7:0]  ctrl3_nxt;
   logic [15:0] reload2_r;
   logic [15:0] reload2_nxt;
   logic [15:0] reload3_r;
   logic [15:0] reload3_nxt;
   logic [1:0]  status_r;
   logic [1:0]  status_nxt;
   logic [1:0]  mask_r;
   logic [1:0]  mask_nxt;
   logic        irq_r;
   logic        irq_nxt;
   logic        lfo_q_r;
   logic        lfo_q_nxt;
   logic [27:0] sys_acc_r;
   logic [27:0] sys_acc_nxt;
   logic [27:0] low_acc_r;
   logic [27:0] low_acc_nxt;
   logic        sys_tick_r;
   logic        sys_tick_nxt;
   logic        low_tick_r;
   logic        low_tick_nxt;

   logic        wr_fire;
   logic [7:0]  wr_idx;
   logic        wr_ok;
   logic        wr_en;
   logic [7:0]  cmd;
   logic [7:0]  rd_idx;
   logic        rd_ok;
   logic [7:0]  rd_byte;
   logic [15:0] count2;
   logic [15:0] count3;
   logic        run2;
   logic        run3;
   logic        uf2;
   logic        uf3;
   logic        lfo_rise;
   logic        trim2;
   logic        trim3;
   logic        start2;
   logic        stop2;
   logic        start3;
   logic        stop3;
   logic        tick2;
   logic        tick3;

   function automatic logic pick_tick(input logic [1:0] sel,
                                      input logic       sys_t,
                                      input logic       low_t,
                                      input logic       uf0,
                                      input logic       uf1);
      logic t;
      t = 1'b0;
      case (rct_pkg::rct_tick_sel_t'(sel))
         rct_pkg::RCT_TICK_SYS:  t = sys_t;
         rct_pkg::RCT_TICK_LOW:  t = low_t;
         rct_pkg::RCT_TICK_ZERO: t = uf0;
         rct_pkg::RCT_TICK_ONE:  t = uf1;
         default:                t = 1'b0;
      endcase
      return t;
   endfunction

   // write channel
   assign wr_fire = aw_held_r && w_held_r && (wr_state_r == rct_pkg::RCT_WR_WAIT);
   assign wr_idx  = aw_addr_r[9:2];
   assign wr_en   = wr_fire && wr_ok && w_lane_r;

   always_comb begin
      wr_ok = 1'b0;
      if (aw_addr_r[11:10] == 2'h0) begin
         case (wr_idx)
            `RCT_IDX_T2_CTRL, `RCT_IDX_T2_RLD_HI, `RCT_IDX_T2_RLD_LO,
            `RCT_IDX_T3_CTRL, `RCT_IDX_STATUS, `RCT_IDX_MASK,
            `RCT_IDX_T3_RLD_HI, `RCT_IDX_T3_RLD_LO, `RCT_IDX_COMMAND: wr_ok = 1'b1;
            default: wr_ok = 1'b0;
         endcase
      end
   end

   always_comb begin
      wr_state_nxt = wr_state_r;
      aw_held_nxt  = aw_held_r;
      aw_addr_nxt  = aw_addr_r;
      w_held_nxt   = w_held_r;
      w_byte_nxt   = w_byte_r;
      w_lane_nxt   = w_lane_r;
      bvalid_nxt   = bvalid_r;
      bresp_nxt    = bresp_r;
      if (s_axi_awvalid && awready_r) begin
         aw_held_nxt = 1'b1;
         aw_addr_nxt = s_axi_awaddr;
      end
      if (s_axi_wvalid && wready_r) begin
         w_held_nxt = 1'b1;
         w_byte_nxt = s_axi_wdata[7:0];
         w_lane_nxt = s_axi_wstrb[0];
      end
      case (wr_state_r)
         rct_pkg::RCT_WR_WAIT: begin
            if (wr_fire) begin
               aw_held_nxt  = 1'b0;
               w_held_nxt   = 1'b0;
               bvalid_nxt   = 1'b1;
               bresp_nxt    = wr_ok ? `RCT_RESP_OKAY : `RCT_RESP_SLVERR;
               wr_state_nxt = rct_pkg::RCT_WR_RESP;
            end
         end
         rct_pkg::RCT_WR_RESP: begin
            if (s_axi_bready) begin
               bvalid_nxt   = 1'b0;
               wr_state_nxt = rct_pkg::RCT_WR_WAIT;
            end
         end
         default: wr_state_nxt = rct_pkg::RCT_WR_WAIT;
      endcase
      awready_nxt = !aw_held_nxt;
      wready_nxt  = !w_held_nxt;
   end

   // read channel, count bytes are live and may be mid-update while receiving
   assign rd_idx = s_axi_araddr[9:2];

   always_comb begin
      rd_ok   = (s_axi_araddr[11:10] == 2'h0);
      rd_byte = 8'h00;
      case (rd_idx)
         // RQ15 control at 19h
         `RCT_IDX_T2_CTRL:   rd_byte = ctrl2_r;
         `RCT_IDX_T2_RLD_HI: rd_byte = reload2_r[15:8];
         `RCT_IDX_T2_RLD_LO: rd_byte = reload2_r[7:0];
         // RQ12 live count bytes
         `RCT_IDX_T2_CNT_HI: rd_byte = count2[15:8];
         `RCT_IDX_T2_CNT_LO: rd_byte = count2[7:0];
         `RCT_IDX_T3_CTRL:   rd_byte = ctrl3_r;
         `RCT_IDX_STATUS:    rd_byte = {6'h00, status_r};
         `RCT_IDX_MASK:      rd_byte = {6'h00, mask_r};
         `RCT_IDX_T3_RLD_HI: rd_byte = reload3_r[15:8];
         `RCT_IDX_T3_RLD_LO: rd_byte = reload3_r[7:0];
         `RCT_IDX_T3_CNT_HI: rd_byte = count3[15:8];
         `RCT_IDX_T3_CNT_LO: rd_byte = count3[7:0];
         `RCT_IDX_COMMAND:   rd_byte = 8'h00;
         default:            rd_ok   = 1'b0;
      endcase
   end

   always_comb begin
      rd_state_nxt = rd_state_r;
      arready_nxt  = arready_r;
      rvalid_nxt   = rvalid_r;
      rresp_nxt    = rresp_r;
      rdata_nxt    = rdata_r;
      case (rd_state_r)
         rct_pkg::RCT_RD_IDLE: begin
            if (s_axi_arvalid && arready_r) begin
               arready_nxt  = 1'b0;
               rvalid_nxt   = 1'b1;
               rresp_nxt    = rd_ok ? `RCT_RESP_OKAY : `RCT_RESP_SLVERR;
               rdata_nxt    = rd_ok ? {24'h000000, rd_byte} : 32'h00000000;
               rd_state_nxt = rct_pkg::RCT_RD_DATA;
            end
         end
         rct_pkg::RCT_RD_DATA: begin
            if (s_axi_rready) begin
               arready_nxt  = 1'b1;
               rvalid_nxt   = 1'b0;
               rd_state_nxt = rct_pkg::RCT_RD_IDLE;
            end
         end
         default: rd_state_nxt = rct_pkg::RCT_RD_IDLE;
      endcase
   end

   // software registers
   always_comb begin
      ctrl2_nxt   = ctrl2_r;
      ctrl3_nxt   = ctrl3_r;
      reload2_nxt = reload2_r;
      reload3_nxt = reload3_r;
      mask_nxt    = mask_r;
      cmd         = 8'h00;
      if (wr_en) begin
         case (wr_idx)
            // RQ18 reserved bits dropped
            `RCT_IDX_T2_CTRL:   ctrl2_nxt = w_byte_r & `RCT_CTRL_MASK;
            // RQ14 same layout
            `RCT_IDX_T3_CTRL:   ctrl3_nxt = w_byte_r & `RCT_CTRL_MASK;
            // RQ11 held until next start or auto-reload
            `RCT_IDX_T2_RLD_HI: reload2_nxt[15:8] = w_byte_r;
            `RCT_IDX_T2_RLD_LO: reload2_nxt[7:0]  = w_byte_r;
            `RCT_IDX_T3_RLD_HI: reload3_nxt[15:8] = w_byte_r;
            `RCT_IDX_T3_RLD_LO: reload3_nxt[7:0]  = w_byte_r;
            `RCT_IDX_MASK:      mask_nxt = w_byte_r[1:0];
            `RCT_IDX_COMMAND:   cmd = w_byte_r;
            default:            cmd = 8'h00;
         endcase
      end
   end

   // status, set beats a same-cycle clear
   always_comb begin
      status_nxt = status_r;
      if (wr_en && (wr_idx == `RCT_IDX_STATUS)) begin
         status_nxt = status_r & ~w_byte_r[1:0];
      end
      // RQ7 flag on underflow
      if (uf2) begin
         status_nxt[`RCT_ST_T2_BIT] = 1'b1;
      end
      if (uf3) begin
         status_nxt[`RCT_ST_T3_BIT] = 1'b1;
      end
      irq_nxt = |(status_r & mask_r);
   end

   // tick generation, fractional so the average rate is exact
   always_comb begin
      sys_tick_nxt = 1'b0;
      low_tick_nxt = 1'b0;
      sys_acc_nxt  = sys_acc_r + SYS_HZ;
      low_acc_nxt  = low_acc_r + LOW_HZ;
      // RQ8 system and slow ticks
      if (sys_acc_nxt >= CLK_HZ) begin
         sys_acc_nxt  = sys_acc_nxt - CLK_HZ;
         sys_tick_nxt = 1'b1;
      end
      if (low_acc_nxt >= CLK_HZ) begin
         low_acc_nxt  = low_acc_nxt - CLK_HZ;
         low_tick_nxt = 1'b1;
      end
      lfo_q_nxt = low_freq_oscillator;
   end

   // start and stop decisions
   assign lfo_rise = low_freq_oscillator && !lfo_q_r;
   // RQ4 trimming modes
   assign trim2 = ctrl2_r[`RCT_START_MSB];
   assign trim3 = ctrl3_r[`RCT_START_MSB];

   // RQ3 manual or end of send
   assign start2 = cmd[`RCT_CMD_START2_BIT]
                 || ((ctrl2_r[`RCT_START_MSB:`RCT_START_LSB] == 2'(rct_pkg::RCT_START_TX_END))
                     && tx_end)
                 || (trim2 && lfo_rise && !run2);
   // RQ1 stop on receive
   // RQ2 ignored when trimming
   assign stop2  = cmd[`RCT_CMD_STOP2_BIT]
                 || (trim2 && lfo_rise && run2)
                 || (!trim2 && ctrl2_r[`RCT_STOP_RX_BIT] && rx_first_nibble);
   // RQ14 third timer alike
   assign start3 = cmd[`RCT_CMD_START3_BIT]
                 || ((ctrl3_r[`RCT_START_MSB:`RCT_START_LSB] == 2'(rct_pkg::RCT_START_TX_END))
                     && tx_end)
                 || (trim3 && lfo_rise && !run3);
   assign stop3  = cmd[`RCT_CMD_STOP3_BIT]
                 || (trim3 && lfo_rise && run3)
                 || (!trim3 && ctrl3_r[`RCT_STOP_RX_BIT] && rx_first_nibble);

   // RQ9 cascade tick select
   assign tick2 = pick_tick(ctrl2_r[`RCT_TICK_MSB:`RCT_TICK_LSB], sys_tick_r, low_tick_r,
                            timer_zero_underflow, timer_one_underflow);
   assign tick3 = pick_tick(ctrl3_r[`RCT_TICK_MSB:`RCT_TICK_LSB], sys_tick_r, low_tick_r,
                            timer_zero_underflow, timer_one_underflow);

   // RQ5 second timer counter
   rct_down_counter u_second (
      .clock        (clock),
      .nrst         (nrst),
      .start        (start2),
      .stop         (stop2),
      .tick         (tick2),
      .reload_value (reload2_r),
      .auto_reload  (ctrl2_r[`RCT_AUTO_BIT]),
      .wrap_en      (ctrl2_r[`RCT_START_LSB] || !trim2),
      .count        (count2),
      .running      (run2),
      .underflow    (uf2)
   );

   // RQ16 third timer counter
   rct_down_counter u_third (
      .clock        (clock),
      .nrst         (nrst),
      .start        (start3),
      .stop         (stop3),
      .tick         (tick3),
      .reload_value (reload3_r),
      .auto_reload  (ctrl3_r[`RCT_AUTO_BIT]),
      .wrap_en      (ctrl3_r[`RCT_START_LSB] || !trim3),
      .count        (count3),
      .running      (run3),
      .underflow    (uf3)
   );

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         wr_state_r <= rct_pkg::RCT_WR_WAIT;
         rd_state_r <= rct_pkg::RCT_RD_IDLE;
         aw_held_r  <= 1'b0;
         aw_addr_r  <= 12'h000;
         w_held_r   <= 1'b0;
         w_byte_r   <= 8'h00;
         w_lane_r   <= 1'b0;
         awready_r  <= 1'b1;
         wready_r   <= 1'b1;
         bvalid_r   <= 1'b0;
         bresp_r    <= `RCT_RESP_OKAY;
         arready_r  <= 1'b1;
         rvalid_r   <= 1'b0;
         rresp_r    <= `RCT_RESP_OKAY;
         rdata_r    <= 32'h00000000;
         ctrl2_r    <= `RCT_CTRL_RST;
         ctrl3_r    <= `RCT_CTRL_RST;
         reload2_r  <= {`RCT_RELOAD_RST, `RCT_RELOAD_RST};
         reload3_r  <= {`RCT_RELOAD_RST, `RCT_RELOAD_RST};
         status_r   <= 2'h0;
         mask_r     <= `RCT_MASK_RST;
         irq_r      <= 1'b0;
         lfo_q_r    <= 1'b0;
         sys_acc_r  <= 28'h0000000;
         low_acc_r  <= 28'h0000000;
         sys_tick_r <= 1'b0;
         low_tick_r <= 1'b0;
      end else begin
         wr_state_r <= wr_state_nxt;
         rd_state_r <= rd_state_nxt;
         aw_held_r  <= aw_held_nxt;
         aw_addr_r  <= aw_addr_nxt;
         w_held_r   <= w_held_nxt;
         w_byte_r   <= w_byte_nxt;
         w_lane_r   <= w_lane_nxt;
         awready_r  <= awready_nxt;
         wready_r   <= wready_nxt;
         bvalid_r   <= bvalid_nxt;
         bresp_r    <= bresp_nxt;
         arready_r  <= arready_nxt;
         rvalid_r   <= rvalid_nxt;
         rresp_r    <= rresp_nxt;
         rdata_r    <= rdata_nxt;
         ctrl2_r    <= ctrl2_nxt;
         ctrl3_r    <= ctrl3_nxt;
         reload2_r  <= reload2_nxt;
         reload3_r  <= reload3_nxt;
         status_r   <= status_nxt;
         mask_r     <= mask_nxt;
         irq_r      <= irq_nxt;
         lfo_q_r    <= lfo_q_nxt;
         sys_acc_r  <= sys_acc_nxt;
         low_acc_r  <= low_acc_nxt;
         sys_tick_r <= sys_tick_nxt;
         low_tick_r <= low_tick_nxt;
      end
   end

   assign s_axi_awready          = awready_r;
   assign s_axi_wready           = wready_r;
   assign s_axi_bvalid           = bvalid_r;
   assign s_axi_bresp            = bresp_r;
   assign s_axi_arready          = arready_r;
   assign s_axi_rvalid           = rvalid_r;
   assign s_axi_rresp            = rresp_r;
   assign s_axi_rdata            = rdata_r;
   assign irq                    = irq_r;
   assign second_timer_underflow = uf2;
   assign third_timer_underflow  = uf3;
   assign second_timer_running   = run2;
   assign third_timer_running    = run3;

endmodule // rct_timer

// ---- tb/rct_timer_properties.sv ----
`timescale 1ns/1ps
module rct_timer_properties (
   input wire logic        clock,
   input wire logic        nrst,
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_awready,
   input wire logic        s_axi_wvalid,
   input wire logic        s_axi_wready,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic [1:0]  s_axi_bresp,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0]  s_axi_rresp,
   input wire logic        second_timer_underflow,
   input wire logic        second_timer_running
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (!nrst);
   AST_WR_ANSWER: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
      && s_axi_wready && !s_axi_bvalid |-> ##2 s_axi_bvalid) else $error("late bvalid");
   AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
      && $stable(s_axi_bresp)) else $error("bresp dropped");
   AST_RD_ANSWER: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("late rvalid");
   AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
      && $stable(s_axi_rdata)) else $error("rdata dropped");
   AST_R_BYTE: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
      else $error("upper rdata set");
   AST_R_ERR: assert property (s_axi_rvalid && s_axi_rresp == 2'h2 |-> s_axi_rdata == 32'h0)
      else $error("error read carries data");
   AST_AR_BUSY: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("arready early");
   AST_UF_RUN: assert property (second_timer_underflow |-> $past(second_timer_running))
      else $error("underflow while idle");
   cover property (second_timer_underflow);
   cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
   cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
endmodule // rct_timer_properties
bind rct_timer rct_timer_properties u_props (.clock(clock), .nrst(nrst),
   .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
   .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
   .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp), .s_axi_arvalid(s_axi_arvalid),
   .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
   .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
   .second_timer_underflow(second_timer_underflow),
   .second_timer_running(second_timer_running));

// ---- tb/tb_reader_cascadable_timer_two.sv ----
`timescale 1ns/1ps
module tb_reader_cascadable_timer_two;
   logic        clock = 1'b0;
   logic        nrst = 1'b0;
   logic [11:0] awa = 12'h0, ara = 12'h0;
   logic        awv = 1'b0, wv = 1'b0, br = 1'b0, arv = 1'b0, rr = 1'b0;
   logic [31:0] wd = 32'h0, rdat, d;
   logic [3:0]  ws = 4'h0;
   logic [4:0]  ev = 5'h0;
   logic        awr, wr_rdy, bv, arr, rv, irq, uf2, uf3, run2, run3;
   logic [1:0]  bresp, rresp, r;
   int          bad_count = 0, num_checks = 0;
   always #5 clock = ~clock;
   rct_timer u_dut (.clock(clock), .nrst(nrst), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
      .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv),
      .s_axi_wready(wr_rdy), .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(br),
      .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdat),
      .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rr), .tx_end(ev[0]),
      .rx_first_nibble(ev[1]), .low_freq_oscillator(ev[2]), .timer_zero_underflow(ev[3]),
      .timer_one_underflow(ev[4]), .irq(irq), .second_timer_underflow(uf2),
      .third_timer_underflow(uf3), .second_timer_running(run2), .third_timer_running(run3));
   task automatic chk(input logic [33:0] got, input logic [33:0] exp);
      num_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic fc(input logic got, input logic exp);
      chk({33'h0, got}, {33'h0, exp});
   endtask
   task automatic wc(input logic [7:0] idx, input logic [7:0] v, input logic [1:0] er);
      logic a, w;
      a = 1'b0;
      w = 1'b0;
      awa <= {2'b00, idx, 2'b00};
      wd <= {24'h0, v};
      ws <= 4'hF;
      awv <= 1'b1;
      wv <= 1'b1;
      br <= 1'b1;
      while (!(a && w)) begin
         @(posedge clock);
         if (awv && awr) begin
            a = 1'b1;
            awv <= 1'b0;
         end
         if (wv && wr_rdy) begin
            w = 1'b1;
            wv <= 1'b0;
         end
      end
      do @(posedge clock); while (!bv);
      chk({32'h0, bresp}, {32'h0, er});
      br <= 1'b0;
      @(posedge clock);
   endtask
   task automatic rd(input logic [7:0] idx);
      ara <= {2'b00, idx, 2'b00};
      arv <= 1'b1;
      rr <= 1'b1;
      do @(posedge clock); while (!arr);
      arv <= 1'b0;
      do @(posedge clock); while (!rv);
      d = rdat;
      r = rresp;
      rr <= 1'b0;
      @(posedge clock);
   endtask
   task automatic rc(input logic [7:0] idx, input logic [31:0] exp);
      rd(idx);
      chk({r, d}, {2'h0, exp});
   endtask
   // pulse one event input; last edge lets the result land
   task automatic pls(input int k);
      ev[k] <= 1'b1;
      @(posedge clock);
      ev[k] <= 1'b0;
      @(posedge clock);
      @(posedge clock);
   endtask
   // count bytes read only while the receiver is idle
   // fractional ticks jitter, so a window not an exact count
   task automatic spd(input logic [7:0] ctl, input int lo, input int hi);
      wc(8'h19, ctl, 2'h0);
      wc(8'h36, 8'h01, 2'h0);
      repeat (1000) @(posedge clock);
      wc(8'h36, 8'h02, 2'h0);
      rd(8'h1D);
      fc(d >= lo && d <= hi, 1'b1);
   endtask
   task conclude;
      $display("checks=%0d mismatches=%0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   initial begin
      #300000;
      bad_count++;
      conclude;
   end
   initial begin
      repeat (6) @(posedge clock);
      nrst <= 1'b1;
      @(posedge clock);
      rc(8'h19, 32'h0);
      wc(8'h19, 8'hFF, 2'h0);
      rc(8'h19, 32'hBB);
      wc(8'h1F, 8'hFF, 2'h0);
      rc(8'h1F, 32'hBB);
      wc(8'h1C, 8'h12, 2'h2);
      rd(8'h3F);
      chk({r, d}, {2'h2, 32'h0});
      wc(8'h31, 8'h01, 2'h0);
      wc(8'h1A, 8'h00, 2'h0);
      wc(8'h1B, 8'h02, 2'h0);
      wc(8'h19, 8'h0A, 2'h0);
      wc(8'h36, 8'h01, 2'h0);
      rc(8'h1D, 32'h2);
      pls(3);
      pls(3);
      wc(8'h1B, 8'h05, 2'h0);
      rc(8'h1D, 32'h0);
      fc(irq, 1'b0);
      pls(3);
      rc(8'h1D, 32'h5);
      fc(irq, 1'b1);
      pls(4);
      rc(8'h1D, 32'h5);
      wc(8'h30, 8'h01, 2'h0);
      fc(irq, 1'b0);
      wc(8'h19, 8'h03, 2'h0);
      wc(8'h36, 8'h01, 2'h0);
      for (int i = 0; i < 6; i++) pls(4);
      fc(run2, 1'b0);
      rc(8'h1D, 32'h0);
      fc(irq, 1'b1);
      wc(8'h30, 8'h01, 2'h0);
      wc(8'h19, 8'h83, 2'h0);
      wc(8'h36, 8'h01, 2'h0);
      pls(1);
      fc(run2, 1'b0);
      wc(8'h19, 8'h03, 2'h0);
      wc(8'h36, 8'h01, 2'h0);
      pls(1);
      fc(run2, 1'b1);
      wc(8'h19, 8'hA3, 2'h0);
      wc(8'h36, 8'h02, 2'h0);
      pls(2);
      fc(run2, 1'b1);
      pls(1);
      fc(run2, 1'b1);
      pls(2);
      fc(run2, 1'b0);
      pls(2);
      for (int i = 0; i < 6; i++) pls(4);
      rc(8'h30, 32'h2);
      wc(8'h19, 8'hB3, 2'h0);
      pls(2);
      for (int i = 0; i < 6; i++) pls(4);
      rc(8'h30, 32'h3);
      wc(8'h30, 8'h03, 2'h0);
      wc(8'h19, 8'h13, 2'h0);
      pls(0);
      fc(run2, 1'b1);
      wc(8'h36, 8'h02, 2'h0);
      wc(8'h19, 8'h03, 2'h0);
      pls(0);
      fc(run2, 1'b0);
      wc(8'h1A, 8'h01, 2'h0);
      wc(8'h1B, 8'h00, 2'h0);
      spd(8'h08, 115, 125);
      spd(8'h09, 252, 255);
      wc(8'h33, 8'h01, 2'h0);
      wc(8'h1F, 8'h0B, 2'h0);
      wc(8'h36, 8'h04, 2'h0);
      pls(4);
      pls(4);
      rc(8'h35, 32'h1);
      fc(run3, 1'b1);
      rc(8'h30, 32'h2);
      conclude;
   end
endmodule // tb_reader_cascadable_timer_two
